// ===== hdl/rcs_pkg.sv
// Purpose: shared constants and types for the radio config serial slave
// Assumes: 100 MHz system clock, serial clock sampled as an ordinary input
// Notes:   header byte is direction, burst, six-bit address from the top bit down
package rcs_pkg;
    localparam int          BYTE_W       = 8;
    localparam int          ADDR_W       = 6;
    localparam int          HDR_RW_BIT   = 7;
    localparam int          HDR_BURST_BIT = 6;
    localparam logic [2:0]  BIT_LAST     = 3'h7;
    localparam logic [2:0]  BIT_FIRST    = 3'h0;
    localparam int          MEM_DEPTH    = 64;
    localparam logic [7:0]  REG_RESET    = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STEP = 6'h01;
    localparam int          STAT_RDY_BIT = 7;
    localparam int          STAT_ST_HI   = 6;
    localparam int          STAT_ST_LO   = 4;

    // header fields as they arrive on the line
    typedef struct packed {
        logic              rd;
        logic              burst;
        logic [ADDR_W-1:0] addr;
    } rcs_header_t;

    // status byte: ready flag low-active, state code, fifo count
    typedef struct packed {
        logic       rdy_n;
        logic [2:0] state;
        logic [3:0] fifo_cnt;
    } rcs_status_t;

    // one register write towards the config store
    typedef struct packed {
        logic              en;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        data;
    } rcs_wr_t;
endpackage

// ===== hdl/rcs_regmem.sv
// Purpose: configuration register store, 64 bytes, registered read data
// Assumes: one write and one read port on the system clock
// Notes:   read data appears the cycle after the address is presented
`timescale 1ns/1ps
module rcs_regmem
    import rcs_pkg::*;
(
    // clock only, no reset
    input  wire logic              clock,
    // write port
    input  wire rcs_wr_t           wr,
    // read port
    input  wire logic [ADDR_W-1:0] rd_addr,
    output      logic [7:0]        rd_data
);
    logic [7:0] mem [MEM_DEPTH];

    always_ff @(posedge clock) begin
        if (wr.en) begin
            mem[wr.addr] <= wr.data;
        end
    end

    always_ff @(posedge clock) begin
        rd_data <= mem[rd_addr];
    end
endmodule

// ===== hdl/rcs_slave.sv
// Purpose: four-wire serial slave port for register and buffered data access
// Assumes: serial clock well below the system clock; all pins synchronised here
// Notes:   mode 0 style, msb first, status byte shifted out during header
`timescale 1ns/1ps
module rcs_slave
    import rcs_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        srst,
    // serial pins
    input  wire logic        chip_select_low,
    input  wire logic        sclk,
    input  wire logic        sdi,
    output      logic        sdo,
    output      logic        sdo_oe,
    // radio core status
    input  wire logic        osc_stable,
    input  wire logic        sleep_state,
    input  wire logic        crystal_off_state,
    input  wire logic [2:0]  main_state,
    input  wire logic [3:0]  rx_fifo_bytes,
    input  wire logic [3:0]  tx_fifo_free,
    // buffered data path
    input  wire logic [7:0]  fifo_rd_data,
    output      logic        fifo_wr_stb,
    output      logic        fifo_rd_stb,
    output      logic [7:0]  fifo_wr_data,
    // config write echo
    output      logic        cfg_wr_stb,
    output      logic [5:0]  cfg_wr_addr,
    output      logic [7:0]  cfg_wr_data
);
    localparam logic [5:0] FIFO_ADDR = 6'h3f;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_HDR  = 3'b010,
        ST_DATA = 3'b100
    } rcs_state_t;

    // two flops per pin; first flop read only by the second
    logic [1:0] cs_s_q, ck_s_q, di_s_q, rdy_s_q;
    logic       ck_prev_q, cs_prev_q;
    always_ff @(posedge clock) begin
        if (srst) begin
            cs_s_q    <= 2'h3;
            ck_s_q    <= 2'h0;
            di_s_q    <= 2'h0;
            rdy_s_q   <= 2'h0;
            ck_prev_q <= 1'b0;
            cs_prev_q <= 1'b1;
        end else begin
            cs_s_q    <= {cs_s_q[0], chip_select_low};
            ck_s_q    <= {ck_s_q[0], sclk};
            di_s_q    <= {di_s_q[0], sdi};
            rdy_s_q   <= {rdy_s_q[0], osc_stable};
            ck_prev_q <= ck_s_q[1];
            cs_prev_q <= cs_s_q[1];
        end
    end

    logic cs_act, ck_rise, ck_fall, cs_fall, rdy;
    assign cs_act  = ~cs_s_q[1];
    assign ck_rise = cs_act & ck_s_q[1] & ~ck_prev_q;
    assign ck_fall = cs_act & ~ck_s_q[1] & ck_prev_q;
    assign cs_fall = cs_prev_q & ~cs_s_q[1];
    assign rdy     = rdy_s_q[1];

    rcs_state_t  state_q;
    logic [2:0]  bit_q;
    logic [7:0]  shin_q, shout_q;
    rcs_header_t hdr_q;
    logic        low_power_q;
    logic        byte_done;
    logic [7:0]  rx_byte;
    rcs_wr_t     mem_wr;
    logic [7:0]  mem_rd;
    rcs_status_t status;

    assign rx_byte   = {shin_q[6:0], di_s_q[1]};
    assign byte_done = ck_rise & (bit_q == BIT_LAST);

    always_comb begin
        status.rdy_n    = ~rdy;
        status.state    = main_state;
        status.fifo_cnt = hdr_q.rd ? rx_fifo_bytes : tx_fifo_free;
    end

    // low power at select fall decides sdo behaviour
    always_ff @(posedge clock) begin
        if (srst) begin
            low_power_q <= 1'b0;
        end else if (cs_fall) begin
            low_power_q <= sleep_state | crystal_off_state;
        end else if (rdy) begin
            low_power_q <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (srst || !cs_act) begin
            state_q <= ST_IDLE;
            bit_q   <= BIT_FIRST;
            shin_q  <= REG_RESET;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (rdy && !low_power_q) begin
                        state_q <= ST_HDR;
                    end
                end
                ST_HDR, ST_DATA: begin
                    if (ck_rise) begin
                        bit_q  <= bit_q + 3'h1;
                        shin_q <= rx_byte;
                        if (bit_q == BIT_LAST) begin
                            state_q <= ST_DATA;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            hdr_q <= '0;
        end else if (byte_done && state_q == ST_HDR) begin
            hdr_q <= rx_byte;
        end else if (byte_done && state_q == ST_DATA && hdr_q.burst
                     && hdr_q.addr != FIFO_ADDR) begin
            hdr_q.addr <= hdr_q.addr + ADDR_STEP;
        end
    end

    // writes go to registers or tx fifo
    // only a complete byte is written
    always_comb begin
        mem_wr.en   = byte_done && state_q == ST_DATA && !hdr_q.rd
                      && hdr_q.addr != FIFO_ADDR;
        mem_wr.addr = hdr_q.addr;
        mem_wr.data = rx_byte;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            fifo_wr_stb  <= 1'b0;
            fifo_rd_stb  <= 1'b0;
            fifo_wr_data <= REG_RESET;
            cfg_wr_stb   <= 1'b0;
            cfg_wr_addr  <= '0;
            cfg_wr_data  <= REG_RESET;
        end else begin
            fifo_wr_stb  <= byte_done && state_q == ST_DATA && !hdr_q.rd
                            && hdr_q.addr == FIFO_ADDR;
            // header pop must look at the byte just taken, not the old header
            fifo_rd_stb  <= byte_done && (state_q == ST_HDR
                            ? (rx_byte[HDR_RW_BIT] && rx_byte[ADDR_W-1:0] == FIFO_ADDR)
                            : (hdr_q.rd && hdr_q.burst && hdr_q.addr == FIFO_ADDR));
            fifo_wr_data <= rx_byte;
            cfg_wr_stb   <= mem_wr.en;
            cfg_wr_addr  <= mem_wr.addr;
            cfg_wr_data  <= mem_wr.data;
        end
    end

    rcs_regmem u_mem (
        .clock   (clock),
        .wr      (mem_wr),
        .rd_addr (byte_done && state_q == ST_HDR ? rx_byte[ADDR_W-1:0] : hdr_q.addr),
        .rd_data (mem_rd)
    );

    // status during header and write data, read data otherwise
    // output shifted msb first on falling edge
    always_ff @(posedge clock) begin
        if (srst || !cs_act) begin
            shout_q <= REG_RESET;
        end else begin
            if (state_q == ST_IDLE) begin
                shout_q <= status;
            end else if (ck_rise && state_q == ST_HDR && bit_q == BIT_FIRST) begin
                // fifo count follows the direction bit just taken
                shout_q[STAT_ST_LO-1:0] <= di_s_q[1] ? rx_fifo_bytes : tx_fifo_free;
            end else if (ck_fall && state_q == ST_DATA && bit_q == BIT_FIRST) begin
                // load on the fall after a byte, so its msb is not shifted away
                shout_q <= !hdr_q.rd ? status
                           : (hdr_q.addr == FIFO_ADDR ? fifo_rd_data : mem_rd);
            end else if (ck_fall) begin
                shout_q <= {shout_q[6:0], 1'b0};
            end
        end
    end

    // output high until oscillator stable after low-power wake
    always_ff @(posedge clock) begin
        if (srst) begin
            sdo    <= 1'b1;
            sdo_oe <= 1'b0;
        end else begin
            sdo_oe <= cs_act;
            if (state_q == ST_IDLE) begin
                sdo <= ~rdy | low_power_q;
            end else begin
                sdo <= shout_q[STAT_RDY_BIT];
            end
        end
    end

    a_cs_clears_bits: assert property (@(posedge clock) disable iff (srst)
        !cs_act |=> bit_q == BIT_FIRST && state_q == ST_IDLE)
        else $error("bit counter not cleared by select high");
    a_no_partial_wr: assert property (@(posedge clock) disable iff (srst)
        !cs_act |=> !mem_wr.en)
        else $error("write while deselected");
    a_burst_step: assert property (@(posedge clock) disable iff (srst)
        byte_done && state_q == ST_DATA && hdr_q.burst && hdr_q.addr != FIFO_ADDR
        |=> hdr_q.addr == $past(hdr_q.addr) + ADDR_STEP)
        else $error("burst address did not step");
    a_sdo_not_ready: assert property (@(posedge clock) disable iff (srst)
        state_q == ST_IDLE && !rdy && cs_act |=> sdo)
        else $error("output low before oscillator stable");
    // header latched from the first byte
    a_hdr_latch: assert property (@(posedge clock) disable iff (srst)
        byte_done && state_q == ST_HDR |=> hdr_q == $past(rx_byte) && state_q == ST_DATA)
        else $error("header not captured");
    a_status_rdy: assert property (@(posedge clock) disable iff (srst)
        status.rdy_n == !rdy && status.state == main_state)
        else $error("status byte fields wrong");
    a_status_hdr: assert property (@(posedge clock) disable iff (srst)
        state_q == ST_IDLE && cs_act |=> shout_q == $past(status))
        else $error("status not loaded for header");
    // fifo write strobe follows fifo address byte
    a_fifo_wr: assert property (@(posedge clock) disable iff (srst)
        byte_done && state_q == ST_DATA && !hdr_q.rd && hdr_q.addr == FIFO_ADDR
        |=> fifo_wr_stb ##1 !fifo_wr_stb)
        else $error("fifo write strobe wrong");
    a_bit_step: assert property (@(posedge clock) disable iff (srst)
        ck_rise && state_q != ST_IDLE |=> bit_q == $past(bit_q) + 3'h1)
        else $error("bit counter did not advance");
endmodule

// ===== testbench/rcs_master_model.sv
// Purpose: behavioural serial master driving the slave pins
// Assumes: serial clock idles low, 125 ns period, bits set after the fall
// Notes:   a released output reads as a toggling level, never a stale bit
`timescale 1ns/1ps
module rcs_master_model (
    // polling clock
    input  wire logic clock,
    // serial pins
    input  wire logic sdo,
    input  wire logic sdo_oe,
    output      logic chip_select_low,
    output      logic sclk,
    output      logic sdi
);
    logic junk_q = 1'b0;
    logic so_line;

    always @(posedge clock) junk_q <= ~junk_q;
    assign so_line = sdo_oe ? sdo : junk_q;

    initial begin
        chip_select_low = 1'b1;
        sclk            = 1'b0;
        sdi             = 1'b0;
    end

    task automatic begin_frame(output bit ok);
        int n;
        n = 0;
        @(negedge clock) chip_select_low = 1'b0;
        for (int i = 0; i < 400 && n < 3; i++) begin
            @(negedge clock);
            n = (so_line === 1'b0) ? n + 1 : 0;
        end
        ok = (n == 3);
        // odd offset keeps every link edge clear of system clock edges
        #101.25;
    endtask

    task automatic shift(input logic [7:0] tx, input int nb, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nb; i--) begin
            sdi = tx[i];
            #62.5 sclk = 1'b1;
            rx[i] = so_line;
            #62.5 sclk = 1'b0;
        end
        #100;
    endtask

    task automatic end_frame();
        #30 chip_select_low = 1'b1;
        repeat (8) @(posedge clock);
    endtask
endmodule

// ===== testbench/radio_config_serial_slave_tb_top.sv
// Purpose: self-checking bench for the serial slave port
// Assumes: 100 MHz clock, master model shifting at 125 ns
// Notes:   strobes are logged and compared once the frames of each test are done
`timescale 1ns/1ps
module radio_config_serial_slave_tb_top
    import rcs_pkg::*;
();
    logic        clock = 1'b0;
    logic        srst  = 1'b1;
    logic        chip_select_low, sclk, sdi, sdo, sdo_oe;
    logic        osc_stable = 1'b1, sleep_state = 1'b0, crystal_off_state = 1'b0;
    logic [2:0]  main_state = 3'h5;
    logic [3:0]  rx_fifo_bytes = 4'h9, tx_fifo_free = 4'hc;
    logic [7:0]  fifo_rd_data = 8'h5a;
    logic        fifo_wr_stb, fifo_rd_stb, cfg_wr_stb;
    logic [7:0]  fifo_wr_data, cfg_wr_data;
    logic [5:0]  cfg_wr_addr;
    logic [13:0] cfg_log[$];
    logic [7:0]  fwr_log[$];
    logic [7:0]  rxb[0:3];
    int          n_rd, cycles, failures, n_tests;

    always #5 clock = ~clock;

    rcs_slave dut (.clock, .srst, .chip_select_low, .sclk, .sdi, .sdo, .sdo_oe,
        .osc_stable, .sleep_state, .crystal_off_state, .main_state, .rx_fifo_bytes,
        .tx_fifo_free, .fifo_rd_data, .fifo_wr_stb, .fifo_rd_stb, .fifo_wr_data,
        .cfg_wr_stb, .cfg_wr_addr, .cfg_wr_data);

    rcs_master_model m (.clock, .sdo, .sdo_oe, .chip_select_low, .sclk, .sdi);

    always @(negedge clock) begin
        if (cfg_wr_stb === 1'b1) cfg_log.push_back({cfg_wr_addr, cfg_wr_data});
        if (fifo_wr_stb === 1'b1) fwr_log.push_back(fifo_wr_data);
        if (fifo_rd_stb === 1'b1) n_rd++;
        cycles++;
        if (cycles == 30000) begin
            failures++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("Counts: %0d checks, %0d mismatches", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    // full frame: header then n data bytes, status checked on the way
    task automatic access(input logic [7:0] hdr, input int n, input logic [7:0] d0);
        bit         ok;
        logic [7:0] r;
        logic [7:0] st;
        st = {1'b0, main_state, hdr[7] ? rx_fifo_bytes : tx_fifo_free};
        m.begin_frame(ok);
        chk(16'(ok), 16'h0001); // ready shown
        m.shift(hdr, 8, r);
        chk(16'(r), 16'(st)); // status on header
        for (int i = 0; i < n; i++) begin
            m.shift(hdr[7] ? 8'h00 : d0 + 8'(i), 8, rxb[i]);
            if (!hdr[7]) chk(16'(rxb[i]), 16'(st)); // status on write data
        end
        m.end_frame();
    endtask

    initial begin
        logic [7:0] r;
        bit         ok;
        repeat (16) @(posedge clock);
        @(negedge clock) srst = 1'b0;
        repeat (4) @(posedge clock);
        access(8'h05, 1, 8'h3c);
        chk(16'(cfg_log[0]), {2'h0, 6'h05, 8'h3c}); // single write address
        // every state code, read back on each
        for (int s = 0; s < 8; s++) begin
            @(negedge clock) main_state = 3'(s);
            rx_fifo_bytes = 4'(15 - s);
            access(8'h85, 1, 8'h00);
            chk(16'(rxb[0]), 16'h003c); // readback of register 5; state is checked in the header status
        end
        $display("done: single access and status");
        access(8'h50, 3, 8'ha0);
        access(8'hd0, 3, 8'h00);
        for (int i = 0; i < 3; i++) begin
            chk(16'(cfg_log[1 + i]), {2'h0, 6'h10 + 6'(i), 8'ha0 + 8'(i)}); // burst write
            chk(16'(rxb[i]), 16'(8'ha0 + 8'(i))); // burst read
        end
        $display("done: burst");
        // cut inside header, then inside data byte
        m.begin_frame(ok);
        m.shift(8'h07, 5, r);
        m.end_frame();
        m.begin_frame(ok);
        m.shift(8'h07, 8, r);
        m.shift(8'hff, 4, r);
        m.end_frame();
        chk(16'(cfg_log.size()), 16'h0004); // no partial write
        access(8'h08, 1, 8'h66);
        chk(16'(cfg_log[4]), {2'h0, 6'h08, 8'h66}); // next byte is header
        $display("done: abort");
        access(8'h3f, 1, 8'ha7);
        chk(16'(fwr_log[0]), 16'h00a7); // buffered write
        access(8'hbf, 1, 8'h00);
        chk(16'(rxb[0]), 16'h005a); // buffered read
        chk(16'(n_rd != 0), 16'h0001); // pop issued
        $display("done: buffered data");
        // asleep or crystal off: output held high until stable
        for (int k = 0; k < 2; k++) begin
            @(negedge clock) osc_stable = 1'b0;
            sleep_state = (k == 0);
            crystal_off_state = (k == 1);
            fork
                access(8'h85, 1, 8'h00);
                begin
                    repeat (40) @(negedge clock);
                    chk(16'({sdo_oe, sdo}), 16'h0003); // high while not ready
                    @(negedge clock) osc_stable = 1'b1;
                end
            join
            chk(16'(rxb[0]), 16'h003c); // access after wake
            @(negedge clock) sleep_state = 1'b0;
            crystal_off_state = 1'b0;
        end
        $display("done: wake from low power");
        complete_run();
    end
endmodule
